/* File: hw/ahp_pkg.sv */
package ahp_pkg;

    // ********
    // Widths
    // ********
    localparam int ADDR_W   = 20;
    localparam int HDATA_W  = 16;
    localparam int IDATA_W  = 32;
    localparam int NUM_REGS = 41;

    // ********
    // Address regions, taken from address bits [19:16]
    // ********
    localparam logic [3:0] REGION_REGS = 4'h0;
    localparam logic [3:0] REGION_VC   = 4'h1;
    localparam logic [3:0] REGION_DATA = 4'h2;
    localparam logic [3:0] REGION_CONN = 4'h4;

    // Register space below the low offset and from the high offset upward is reserved
    localparam logic [15:0] REG_SPACE_LO = 16'h0100;
    localparam logic [15:0] REG_SPACE_HI = 16'h0700;

    // Memory selects on the internal memory port
    localparam logic [1:0] MEM_SEL_VC   = 2'h0;
    localparam logic [1:0] MEM_SEL_DATA = 2'h1;
    localparam logic [1:0] MEM_SEL_CONN = 2'h2;

    // ********
    // Register map, dword offsets
    // ********
    localparam logic [19:0] REG_OFFSET [NUM_REGS] = '{
        20'h00100, 20'h00104, 20'h00108, 20'h0010c, 20'h00114,
        20'h00118, 20'h00120, 20'h00124, 20'h00128, 20'h00140,
        20'h00144, 20'h00148, 20'h00200, 20'h00204, 20'h00208,
        20'h0020c, 20'h00210, 20'h00214, 20'h00220, 20'h00224,
        20'h00228, 20'h00300, 20'h00320, 20'h00400, 20'h00410,
        20'h00420, 20'h00430, 20'h00440, 20'h00450, 20'h00460,
        20'h00470, 20'h00474, 20'h00480, 20'h00500, 20'h00600,
        20'h00604, 20'h00608, 20'h0060c, 20'h00610, 20'h00614,
        20'h006fc
    };

    // Indexes into the map for registers with behaviour of their own
    localparam logic [5:0] IDX_TOP_CONTROL       = 6'h00;
    localparam logic [5:0] IDX_CHIP_ID           = 6'h08;
    localparam logic [5:0] IDX_DIAGNOSTIC_WORD_0 = 6'h09;

    // Field positions
    localparam int TOP_SOFT_RESET_LSB = 0;
    localparam int TOP_SOFT_RESET_W   = 8;
    localparam int DIAG_VC_ENABLE_BIT = 0;
    localparam int ID_VERSION_LSB     = 0;
    localparam int ID_DEVICE_LSB      = 16;

    // Values after reset
    localparam logic [31:0] REG_RESET   = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [15:0] HDATA_RESET = 16'h0000;
    localparam logic [19:0] ADDR_RESET  = 20'h0_0000;

    // ********
    // Access sequencer
    // ********
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_REG,
        ST_MEM,
        ST_REPLY,
        ST_RELEASE
    } ahp_state_t;

endpackage

/* File: hw/ahp_sync.sv */
`timescale 1ns/1ns
module ahp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

/* File: hw/ahp_port.sv */
`timescale 1ns/1ns
// How it works
// - Strap low enables this port, else idle.
// - Style pin high gives ready handshake, low acknowledge.
// - Width pin high word addressing, low byte.
// - Word uses all lines, byte lower eight only.
// - Address bits 1:0 steer lanes of dword.
// - Read pin is read or data strobe.
// - Write pin is write strobe or direction.
// - Twenty address bits, select qualifies each access.
// - Registers and memories reachable, channel memory gated.
// - Host strobes synchronised before use.
// - Data and connection memory mapped, gaps reserved.
// - Channel memory mapped at 0x10000 to 0x1ffff.
// - Register space split, low and high reserved.
// - Read-only identification dword holds version, device.
// - Reserved reads zero, registers answer at once.
// - Data memory waits for switching traffic.
// - Channel memory access disabled after reset.
module ahp_port #(
    // Arbitrary neutral identity values
    parameter logic [7:0]  VERSION_CODE = 8'h01,
    parameter logic [15:0] DEVICE_CODE  = 16'h0a5a
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        host_interface_strap,
    input  wire logic        handshake_style_pin,
    input  wire logic        width_select_pin,
    input  wire logic [15:0] host_address_lines,
    input  wire logic        upper_address_bit16_pin,
    input  wire logic        upper_address_bit17_pin,
    input  wire logic        upper_address_bit18_pin,
    input  wire logic        upper_address_bit19_pin,
    input  wire logic        host_select_pin,
    input  wire logic        host_read_pin,
    input  wire logic        host_write_pin,
    input  wire logic [15:0] host_data_lines_in,
    output logic      [15:0] host_data_lines_out,
    output logic      [1:0]  host_data_lines_oe,
    output logic             handshake_reply_pin,
    output logic             mem_req,
    output logic      [1:0]  mem_sel,
    output logic      [13:0] mem_addr,
    output logic             mem_we,
    output logic      [3:0]  mem_be,
    output logic      [31:0] mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             port_enabled,
    output logic             vc_access_enabled
);

    // ********
    // Decoding helpers
    // ********
    // Byte enables of the addressed word or byte within the dword
    function automatic logic [3:0] lane_enables(
        input logic       word_mode,
        input logic [1:0] low_addr
    );
        logic [3:0] be;
        be = 4'h0;
        if (word_mode) begin
            be = low_addr[1] ? 4'hc : 4'h3;
        end else begin
            be = 4'h1 << low_addr;
        end
        return be;
    endfunction

    // Finds the register that a dword address selects
    function automatic logic [6:0] reg_lookup(input logic [19:0] addr);
        logic [6:0] res;
        res = 7'h00;
        for (int i = 0; i < ahp_pkg::NUM_REGS; i++) begin
            if (ahp_pkg::REG_OFFSET[i][19:2] == addr[19:2]) begin
                res = {1'b1, 6'(i)};
            end
        end
        return res;
    endfunction

    // ********
    // Strap capture
    // ********
    logic strap_taken_q;
    logic port_en_q;
    logic ready_style_q;

    // Straps are caught on the first edge after reset release
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            strap_taken_q <= 1'b0;
            port_en_q     <= 1'b0;
            ready_style_q <= 1'b1;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            port_en_q     <= !host_interface_strap;
            ready_style_q <= handshake_style_pin;
        end
    end

    assign port_enabled = port_en_q;

    // ********
    // Strobe synchronisers
    // ********
    logic [2:0] strobe_raw;
    logic [2:0] strobe_sync;
    logic       sel_low_s;
    logic       rd_pin_s;
    logic       wr_pin_s;
    logic       strobe_on;
    logic       is_write;

    assign strobe_raw = {host_select_pin, host_read_pin, host_write_pin};

    ahp_sync #(
        .W (3)
    ) u_sync (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .async_in    (strobe_raw),
        .sync_out    (strobe_sync)
    );

    assign sel_low_s = strobe_sync[2];
    assign rd_pin_s  = strobe_sync[1];
    assign wr_pin_s  = strobe_sync[0];

    // Ready style: separate read and write strobes.
    // Acknowledge style: data strobe plus direction, low meaning write.
    always_comb begin
        if (ready_style_q) begin
            strobe_on = !sel_low_s && (!rd_pin_s || !wr_pin_s);
            is_write  = !wr_pin_s;
        end else begin
            strobe_on = !sel_low_s && !rd_pin_s;
            is_write  = !wr_pin_s;
        end
    end

    // ********
    // Access sequencer
    // ********
    ahp_pkg::ahp_state_t state_q;
    logic [19:0]         addr_q;
    logic                wr_q;
    logic                word_q;
    logic [15:0]         wdata_q;
    logic [31:0]         rdata_q;
    logic                reply_q;
    logic [15:0]         hdata_out_q;
    logic [1:0]          hdata_oe_q;
    logic                mem_req_q;
    logic [1:0]          mem_sel_q;
    logic [13:0]         mem_addr_q;
    logic                mem_we_q;
    logic [3:0]          mem_be_q;
    logic [31:0]         mem_wdata_q;
    logic [3:0]          region;
    logic [15:0]         region_off;
    logic [3:0]          acc_be;
    logic [31:0]         acc_wdata;
    logic [6:0]          reg_hit_idx;
    logic                reg_hit;
    logic [5:0]          reg_idx;
    logic                vc_en;
    logic                reg_space;
    logic [31:0]         reg_read_word;

    assign region      = addr_q[19:16];
    assign region_off  = addr_q[15:0];
    assign acc_be      = lane_enables(word_q, addr_q[1:0]);
    assign acc_wdata   = word_q ? {2{wdata_q}}
                                : {4{wdata_q[7:0]}};
    assign reg_hit_idx = reg_lookup(addr_q);
    assign reg_hit     = reg_hit_idx[6];
    assign reg_idx     = reg_hit_idx[5:0];
    assign reg_space   = (region == ahp_pkg::REGION_REGS)
                      && (region_off >= ahp_pkg::REG_SPACE_LO)
                      && (region_off <  ahp_pkg::REG_SPACE_HI);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q     <= ahp_pkg::ST_IDLE;
            addr_q      <= ahp_pkg::ADDR_RESET;
            wr_q        <= 1'b0;
            word_q      <= 1'b1;
            wdata_q     <= ahp_pkg::HDATA_RESET;
            rdata_q     <= ahp_pkg::RDATA_RESET;
            reply_q     <= 1'b1;
            hdata_out_q <= ahp_pkg::HDATA_RESET;
            hdata_oe_q  <= 2'h0;
            mem_req_q   <= 1'b0;
            mem_sel_q   <= ahp_pkg::MEM_SEL_DATA;
            mem_addr_q  <= '0;
            mem_we_q    <= 1'b0;
            mem_be_q    <= 4'h0;
            mem_wdata_q <= ahp_pkg::REG_RESET;
        end else begin
            unique case (state_q)
                ahp_pkg::ST_IDLE: begin
                    if (port_en_q && strobe_on) begin
                        addr_q  <= {upper_address_bit19_pin,
                                    upper_address_bit18_pin,
                                    upper_address_bit17_pin,
                                    upper_address_bit16_pin,
                                    host_address_lines};
                        wr_q    <= is_write;
                        word_q  <= width_select_pin;
                        wdata_q <= host_data_lines_in;
                        // Ready drops as soon as the strobe is seen
                        if (ready_style_q) begin
                            reply_q <= 1'b0;
                        end
                        state_q <= ahp_pkg::ST_DECODE;
                    end
                end
                ahp_pkg::ST_DECODE: begin
                    rdata_q     <= ahp_pkg::RDATA_RESET;
                    mem_addr_q  <= addr_q[15:2];
                    mem_we_q    <= wr_q;
                    mem_be_q    <= acc_be;
                    mem_wdata_q <= acc_wdata;
                    if (reg_space) begin
                        state_q <= ahp_pkg::ST_REG;
                    end else if (region == ahp_pkg::REGION_VC && vc_en) begin
                        mem_sel_q <= ahp_pkg::MEM_SEL_VC;
                        mem_req_q <= 1'b1;
                        state_q   <= ahp_pkg::ST_MEM;
                    end else if (region == ahp_pkg::REGION_DATA) begin
                        mem_sel_q <= ahp_pkg::MEM_SEL_DATA;
                        mem_req_q <= 1'b1;
                        state_q   <= ahp_pkg::ST_MEM;
                    end else if (region == ahp_pkg::REGION_CONN) begin
                        mem_sel_q <= ahp_pkg::MEM_SEL_CONN;
                        mem_req_q <= 1'b1;
                        state_q   <= ahp_pkg::ST_MEM;
                    end else begin
                        // Reserved space: writes dropped, reads zero
                        state_q <= ahp_pkg::ST_REPLY;
                    end
                end
                ahp_pkg::ST_REG: begin
                    // Registers never wait on internal traffic
                    rdata_q <= reg_read_word;
                    state_q <= ahp_pkg::ST_REPLY;
                end
                ahp_pkg::ST_MEM: begin
                    // Request holds until the switching arbiter grants it
                    if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        rdata_q   <= wr_q ? ahp_pkg::RDATA_RESET : mem_rdata;
                        state_q   <= ahp_pkg::ST_REPLY;
                    end
                end
                ahp_pkg::ST_REPLY: begin
                    if (!wr_q) begin
                        if (word_q) begin
                            hdata_out_q <= addr_q[1] ? rdata_q[31:16]
                                                     : rdata_q[15:0];
                            hdata_oe_q  <= 2'h3;
                        end else begin
                            hdata_out_q <= {8'h00,
                                            rdata_q[{addr_q[1:0], 3'h0} +: 8]};
                            hdata_oe_q  <= 2'h1;
                        end
                    end
                    reply_q <= ready_style_q;
                    state_q <= ahp_pkg::ST_RELEASE;
                end
                ahp_pkg::ST_RELEASE: begin
                    // Host ends the cycle by releasing its strobe
                    if (!strobe_on) begin
                        reply_q    <= 1'b1;
                        hdata_oe_q <= 2'h0;
                        state_q    <= ahp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign host_data_lines_out = hdata_out_q;
    assign host_data_lines_oe  = hdata_oe_q;
    assign handshake_reply_pin = reply_q;
    assign mem_req             = mem_req_q;
    assign mem_sel             = mem_sel_q;
    assign mem_addr            = mem_addr_q;
    assign mem_we              = mem_we_q;
    assign mem_be              = mem_be_q;
    assign mem_wdata           = mem_wdata_q;

    // ********
    // Register file
    // ********
    logic [31:0] regs_q [ahp_pkg::NUM_REGS];
    logic        reg_write;
    logic [31:0] chip_id_word;

    assign reg_write = (state_q == ahp_pkg::ST_REG) && wr_q && reg_hit
                    && (reg_idx != ahp_pkg::IDX_CHIP_ID);

    // Byte 1 is reserved and reads zero
    assign chip_id_word = (32'(VERSION_CODE) << ahp_pkg::ID_VERSION_LSB)
                        | (32'(DEVICE_CODE)  << ahp_pkg::ID_DEVICE_LSB);

    always_comb begin
        reg_read_word = ahp_pkg::RDATA_RESET;
        if (reg_hit) begin
            if (reg_idx == ahp_pkg::IDX_CHIP_ID) begin
                reg_read_word = chip_id_word;
            end else begin
                reg_read_word = regs_q[reg_idx];
            end
        end
    end

    generate
        for (genvar g = 0; g < ahp_pkg::NUM_REGS; g++) begin : g_reg
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    regs_q[g] <= ahp_pkg::REG_RESET;
                end else begin
                    // Soft reset byte is a trigger and clears itself
                    if (g == int'(ahp_pkg::IDX_TOP_CONTROL)) begin
                        regs_q[g][ahp_pkg::TOP_SOFT_RESET_LSB +:
                                  ahp_pkg::TOP_SOFT_RESET_W] <= 8'h00;
                    end
                    if (reg_write && reg_idx == 6'(g)) begin
                        for (int b = 0; b < 4; b++) begin
                            if (acc_be[b]) begin
                                regs_q[g][b*8 +: 8] <= acc_wdata[b*8 +: 8];
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    assign vc_en =
        regs_q[ahp_pkg::IDX_DIAGNOSTIC_WORD_0][ahp_pkg::DIAG_VC_ENABLE_BIT];

    // Registered copy so the output comes from a flip-flop
    logic vc_en_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            vc_en_q <= 1'b0;
        end else begin
            vc_en_q <= vc_en;
        end
    end

    assign vc_access_enabled = vc_en_q;

endmodule

/* File: sim/ahp_port_asserts.sv */
`timescale 1ns/1ns
module ahp_port_asserts (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        handshake_style_pin,
    input wire logic        width_select_pin,
    input wire logic [15:0] host_address_lines,
    input wire logic        upper_address_bit16_pin,
    input wire logic        upper_address_bit17_pin,
    input wire logic        upper_address_bit18_pin,
    input wire logic        upper_address_bit19_pin,
    input wire logic        host_select_pin,
    input wire logic        host_read_pin,
    input wire logic        host_write_pin,
    input wire logic [15:0] host_data_lines_out,
    input wire logic [1:0]  host_data_lines_oe,
    input wire logic        handshake_reply_pin,
    input wire logic        mem_req,
    input wire logic [1:0]  mem_sel,
    input wire logic [13:0] mem_addr,
    input wire logic        mem_we,
    input wire logic [3:0]  mem_be,
    input wire logic        mem_ack,
    input wire logic        port_enabled,
    input wire logic        vc_access_enabled
);
    // ********
    // Shared terms
    // ********
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [3:0] up;
    assign up = {upper_address_bit19_pin, upper_address_bit18_pin,
                 upper_address_bit17_pin, upper_address_bit16_pin};
    // Reserved offsets of region 0 skip the register cycle
    sequence s_reg_start;
        port_enabled && $fell(host_select_pin) && up == 4'h0
        && host_address_lines >= ahp_pkg::REG_SPACE_LO
        && host_address_lines < ahp_pkg::REG_SPACE_HI;
    endsequence
    sequence s_ready_reply;
        !handshake_reply_pin [*3] ##1 handshake_reply_pin;
    endsequence
    sequence s_ack_reply;
        handshake_reply_pin [*6] ##1 !handshake_reply_pin;
    endsequence
    // ********
    // Host side
    // ********
    a_gate_off: assert property (!port_enabled |-> handshake_reply_pin
        && host_data_lines_oe == 2'b00 && !mem_req) else $error("port idle");
    a_ready_timing: assert property (s_reg_start
        and handshake_style_pin |-> ##3 s_ready_reply)
        else $error("ready timing wrong");
    a_ack_timing: assert property (s_reg_start
        and !handshake_style_pin |-> s_ack_reply)
        else $error("ack timing wrong");
    a_sync_delay: assert property ($fell(host_select_pin)
        |-> $stable(handshake_reply_pin) [*2]) else $error("reply too early");
    a_read_lanes: assert property (handshake_style_pin
        && $rose(handshake_reply_pin) && !$past(host_select_pin)
        && !$past(host_read_pin)
        |-> host_data_lines_oe == {width_select_pin, 1'b1})
        else $error("read lane enables wrong");
    a_write_quiet: assert property (!host_select_pin && !host_write_pin
        |-> host_data_lines_oe == 2'b00) else $error("driven on write");
    a_data_stands: assert property (handshake_style_pin
        && $rose(handshake_reply_pin) && !$past(host_select_pin)
        |=> $stable(host_data_lines_out) [*2]) else $error("data moved");
    // ********
    // Memory side
    // ********
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_sel)) else $error("req dropped");
    a_mem_drop: assert property (mem_ack |=> !mem_req)
        else $error("req after ack");
    a_reply_waits: assert property (mem_req
        |-> handshake_reply_pin == !handshake_style_pin)
        else $error("answered before memory");
    a_mem_region: assert property ($rose(mem_req)
        |-> mem_addr == host_address_lines[15:2] && (up == 4'h2 ?
        mem_sel == ahp_pkg::MEM_SEL_DATA : up == 4'h4 ?
        mem_sel == ahp_pkg::MEM_SEL_CONN : (up == 4'h1 && vc_access_enabled
        && mem_sel == ahp_pkg::MEM_SEL_VC))) else $error("bad region");
    a_mem_lanes: assert property ($rose(mem_req) && mem_we
        |-> mem_be == (width_select_pin ? 4'h3 << {host_address_lines[1],
        1'b0} : 4'h1 << host_address_lines[1:0])) else $error("bad enables");
endmodule

/* File: sim/ahp_mem_model.sv */
`timescale 1ns/1ns
module ahp_mem_model (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [3:0]  wait_cycles,
    input wire logic        mem_req,
    input wire logic [1:0]  mem_sel,
    input wire logic [13:0] mem_addr,
    input wire logic        mem_we,
    input wire logic [3:0]  mem_be,
    input wire logic [31:0] mem_wdata,
    output logic            mem_ack,
    output logic     [31:0] mem_rdata
);
    logic [31:0] mem [64];
    logic [3:0]  cnt_q;
    logic [5:0]  idx;
    assign idx = {mem_sel, mem_addr[3:0]};
    initial begin
        foreach (mem[i]) mem[i] = 32'h0000_0000;
    end
    // Switching traffic holds the host off for wait_cycles
    // Plain always: the initial block also fills the array
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mem_ack   <= 1'b0;
            cnt_q     <= 4'h0;
            mem_rdata <= 32'h0000_0000;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            cnt_q     <= 4'h0;
            // Data is gone after the ack, never left looking valid
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && cnt_q == wait_cycles) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem[idx];
            for (int b = 0; b < 4; b++) begin
                if (mem_we && mem_be[b]) mem[idx][8*b+:8] <= mem_wdata[8*b+:8];
            end
        end else if (mem_req) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

/* File: sim/ahp_port_tb.sv */
`timescale 1ns/1ns
module ahp_port_tb;
    // Arbitrary identity values
    localparam logic [7:0]  VER = 8'h3c;
    localparam logic [15:0] DEV = 16'h5aa5;
    localparam logic [19:0] RSV [7] = '{20'h00000, 20'h00700, 20'h0fffc,
        20'h30000, 20'h50000, 20'h00110, 20'h10000};
    logic        sys_clk, reset, strap, sty, wsel, sel_n, rd_n, wr_n;
    logic        rp, mreq, mwe, mack, pen, vce;
    logic [1:0]  oe, msel;
    logic [3:0]  mbe, wc;
    logic [13:0] maddr;
    logic [15:0] din, dout, rd;
    logic [19:0] ha;
    logic [31:0] mwd, mrd;
    int          miscompares, comparisons;

    ahp_port #(.VERSION_CODE(VER), .DEVICE_CODE(DEV)) uut (
        .sys_clk(sys_clk), .reset(reset), .host_interface_strap(strap),
        .handshake_style_pin(sty), .width_select_pin(wsel),
        .host_address_lines(ha[15:0]), .upper_address_bit16_pin(ha[16]),
        .upper_address_bit17_pin(ha[17]), .upper_address_bit18_pin(ha[18]),
        .upper_address_bit19_pin(ha[19]), .host_select_pin(sel_n),
        .host_read_pin(rd_n), .host_write_pin(wr_n),
        .host_data_lines_in(din), .host_data_lines_out(dout),
        .host_data_lines_oe(oe), .handshake_reply_pin(rp), .mem_req(mreq),
        .mem_sel(msel), .mem_addr(maddr), .mem_we(mwe), .mem_be(mbe),
        .mem_wdata(mwd), .mem_ack(mack), .mem_rdata(mrd),
        .port_enabled(pen), .vc_access_enabled(vce));
    ahp_mem_model u_mem (
        .sys_clk(sys_clk), .reset(reset), .wait_cycles(wc), .mem_req(mreq),
        .mem_sel(msel), .mem_addr(maddr), .mem_we(mwe), .mem_be(mbe),
        .mem_wdata(mwd), .mem_ack(mack), .mem_rdata(mrd));

    // ********
    // Host tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic fin(input string s);
        $display("test %0s ended", s);
    endtask
    task automatic wait_rp(input logic v);
        for (int n = 0; n < 60; n++) begin
            @(posedge sys_clk);
            #1;
            if (rp === v) return;
        end
        miscompares++;
        $display("BAD t=%0t got=%h exp=%h", $time, rp, v);
        test_done();
    endtask
    // Pins held from start until the answer is seen at a rising edge
    task automatic acc(input logic wr, input logic w, input logic [19:0] a,
                       input logic [15:0] wd);
        @(posedge sys_clk);
        #1;
        ha = a;
        wsel = w;
        din = wd;
        sel_n = 1'b0;
        wr_n = !wr;
        rd_n = sty ? wr : 1'b0;
        if (sty) wait_rp(1'b0);
        wait_rp(sty);
        rd = dout;
        if (!wr) chk(oe, {w, 1'b1});
        sel_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(oe, 2'b00);
        chk(rp, 1'b1);
    endtask
    task automatic wrc(input logic w, input logic [19:0] a,
                       input logic [15:0] d);
        acc(1'b1, w, a, d);
    endtask
    task automatic rdc(input logic w, input logic [19:0] a,
                       input logic [15:0] e);
        acc(1'b0, w, a, 16'h0000);
        chk(rd, e);
    endtask
    task automatic rst(input logic s, input logic p);
        @(posedge sys_clk);
        #1;
        strap = s;
        sty = p;
        reset = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(pen, !s);
        chk(vce, 1'b0);
        chk(rp, 1'b1);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ********
    // Scenarios
    // ********
    initial begin
        reset = 1'b1;
        strap = 1'b0;
        sty = 1'b1;
        wsel = 1'b1;
        ha = 20'h0_0000;
        sel_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        din = 16'h0000;
        wc = 4'h0;
        miscompares = 0;
        comparisons = 0;
        rst(1'b0, 1'b1);
        wrc(1'b1, 20'h00104, 16'h1111);
        wrc(1'b1, 20'h00106, 16'h2222);
        rdc(1'b1, 20'h00104, 16'h1111);
        rdc(1'b0, 20'h00107, 16'h0022);
        wrc(1'b0, 20'h00105, 16'h0077);
        rdc(1'b1, 20'h00104, 16'h7711);
        fin("lanes");
        wrc(1'b1, 20'h00128, 16'hffff);
        rdc(1'b1, 20'h00128, {8'h00, VER});
        rdc(1'b1, 20'h0012a, DEV);
        fin("ident");
        foreach (RSV[i]) begin
            wrc(1'b1, RSV[i], 16'hffff);
            rdc(1'b1, RSV[i], 16'h0000);
        end
        fin("reserved");
        wc = 4'h5;
        wrc(1'b1, 20'h20004, 16'hbeef);
        rdc(1'b1, 20'h20004, 16'hbeef);
        rdc(1'b1, 20'h20006, 16'h0000);
        wc = 4'h0;
        wrc(1'b0, 20'h40003, 16'h005a);
        rdc(1'b1, 20'h40002, 16'h5a00);
        wrc(1'b1, 20'h00140, 16'h0001);
        wc = 4'h2;
        wrc(1'b1, 20'h10000, 16'h4321);
        rdc(1'b1, 20'h10000, 16'h4321);
        fin("memories");
        rst(1'b0, 1'b0);
        rdc(1'b1, 20'h00140, 16'h0000);
        rdc(1'b1, 20'h10000, 16'h0000);
        wrc(1'b1, 20'h00104, 16'habcd);
        rdc(1'b1, 20'h00104, 16'habcd);
        rdc(1'b1, 20'h20004, 16'hbeef);
        fin("ack style");
        rst(1'b1, 1'b1);
        @(posedge sys_clk);
        #1;
        sel_n = 1'b0;
        rd_n = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        chk(rp, 1'b1);
        chk(oe, 2'b00);
        sel_n = 1'b1;
        rd_n = 1'b1;
        fin("strap off");
        test_done();
    end
endmodule

bind ahp_port ahp_port_asserts u_chk (
    .sys_clk, .reset, .handshake_style_pin, .width_select_pin,
    .host_address_lines, .upper_address_bit16_pin, .upper_address_bit17_pin,
    .upper_address_bit18_pin, .upper_address_bit19_pin, .host_select_pin,
    .host_read_pin, .host_write_pin, .host_data_lines_out,
    .host_data_lines_oe, .handshake_reply_pin, .mem_req, .mem_sel,
    .mem_addr, .mem_we, .mem_be, .mem_ack, .port_enabled,
    .vc_access_enabled);
